/* File: common/ctp_pkg.sv */
// shared types and constants for the cascadable timer pairs
// assumes one core clock; control words arrive as plain ports, no bus
package ctp_pkg;

  localparam int CTP_NUM_TIMERS = 4;
  localparam int CTP_NUM_PAIRS  = 2;
  localparam int CTP_CNT_W      = 16;
  localparam int CTP_PSC_W      = 8;

  // prescale select codes
  localparam logic [1:0] CTP_PS_DIV1   = 2'h0;
  localparam logic [1:0] CTP_PS_DIV8   = 2'h1;
  localparam logic [1:0] CTP_PS_DIV64  = 2'h2;
  localparam logic [1:0] CTP_PS_DIV256 = 2'h3;

  // prescale terminal counts (ratio minus one)
  localparam logic [CTP_PSC_W-1:0] CTP_PSC_LIM1   = 8'h00;
  localparam logic [CTP_PSC_W-1:0] CTP_PSC_LIM8   = 8'h07;
  localparam logic [CTP_PSC_W-1:0] CTP_PSC_LIM64  = 8'h3f;
  localparam logic [CTP_PSC_W-1:0] CTP_PSC_LIM256 = 8'hff;
  localparam logic [CTP_PSC_W-1:0] CTP_PSC_RST    = 8'h00;

  localparam logic [CTP_CNT_W-1:0] CTP_CNT_RST = 16'h0000;
  localparam logic [CTP_CNT_W-1:0] CTP_CNT_ONE = 16'h0001;
  localparam logic [CTP_CNT_W-1:0] CTP_CNT_MAX = 16'hffff;

  // per-timer control word; cascade is honoured on lower timers only
  typedef struct packed {
    logic       on;
    logic       stop_in_idle;
    logic       gate;
    logic [1:0] prescale;
    logic       cascade;
    logic       clk_src;
  } ctp_ctrl_t;

  // event pulses toward dma, adc and capture/compare units
  typedef struct packed {
    logic [3:0] dma_req;
    logic       adc_trig;
    logic [1:0] tbase_tick;
  } ctp_evt_t;

  localparam ctp_evt_t CTP_EVT_RST = '0;

endpackage : ctp_pkg

/* File: hdl/ctp_timer_pairs.sv */
// two cascadable pairs of 16-bit timers with flags and event pulses
// assumes pins synchronous to core_clk_i; ce_i low freezes all state
`timescale 1ns/10ps

module ctp_timer_pairs
  import ctp_pkg::*;
(
  input  wire logic                      core_clk_i,  // 250 MHz core clock
  input  wire logic                      rstn_i,      // async reset, low
  input  wire logic                      ce_i,        // clock enable
  input  wire logic                      idle_i,      // device in idle
  input  wire logic                      sleep_i,     // device in sleep
  input  wire ctp_ctrl_t [3:0]           ctrl_i,      // control words
  input  wire logic [3:0][CTP_CNT_W-1:0] period_i,    // period values
  input  wire logic [3:0]                ext_clk_i,   // external clock pins
  input  wire logic [3:0]                gate_i,      // gate pins
  input  wire logic [3:0]                flag_clr_i,  // write zero to flag
  output logic [3:0]                     irq_flag_o,  // sticky flags
  output logic [3:0][CTP_CNT_W-1:0]      count_o,     // counter values
  output ctp_evt_t                       evt_o        // event pulses
);

  // edge detection registers for pins
  logic [3:0] ext_q;
  logic [3:0] gate_q;
  logic [3:0] ext_rise;
  logic [3:0] gate_fall;

  // per-timer derived signals
  logic [3:0] run;
  logic [3:0] int_ok;
  logic [3:0] raw_tick;
  logic [3:0] psc_hit;
  logic [3:0] gate_end;
  logic [3:0] match;
  logic [3:0] flag_set;

  logic [CTP_PSC_W-1:0] psc_q   [4];
  logic [CTP_PSC_W-1:0] psc_d   [4];
  logic [CTP_PSC_W-1:0] psc_lim [4];
  logic [CTP_CNT_W-1:0] cnt_q   [4];
  logic [CTP_CNT_W-1:0] cnt_d   [4];
  logic [3:0]           flag_q;
  logic [3:0]           flag_d;
  ctp_evt_t             evt_q;
  ctp_evt_t             evt_d;

  assign ext_rise  = ext_clk_i & ~ext_q;
  assign gate_fall = ~gate_i & gate_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_q  <= 4'h0;
      gate_q <= 4'h0;
    end else if (ce_i) begin
      ext_q  <= ext_clk_i;
      gate_q <= gate_i;
    end
  end

  // ---------------------------------------------------------------
  // per-timer clock source, gate and prescaler
  // ---------------------------------------------------------------
  for (genvar t = 0; t < CTP_NUM_TIMERS; t++) begin : g_tmr

    // idle halts only when stop_in_idle is set
    assign run[t] = ctrl_i[t].on
                  & ~(idle_i & ctrl_i[t].stop_in_idle);

    // internal clock stops in sleep; external source keeps going
    assign int_ok[t] = ~sleep_i
                     & (~ctrl_i[t].gate | gate_i[t]);

    // external edges are sampled on core_clk_i: sync counter only
    assign raw_tick[t] = run[t]
                       & (ctrl_i[t].clk_src ? ext_rise[t]
                                            : int_ok[t]);

    assign psc_lim[t] = (ctrl_i[t].prescale == CTP_PS_DIV256) ? CTP_PSC_LIM256 :
                        (ctrl_i[t].prescale == CTP_PS_DIV64)  ? CTP_PSC_LIM64  :
                        (ctrl_i[t].prescale == CTP_PS_DIV8)   ? CTP_PSC_LIM8   :
                                                                CTP_PSC_LIM1;

    assign psc_hit[t] = raw_tick[t] & (psc_q[t] == psc_lim[t]);

    assign psc_d[t] = ~run[t]     ? CTP_PSC_RST :
                      psc_hit[t]  ? CTP_PSC_RST :
                      raw_tick[t] ? CTP_PSC_W'(psc_q[t] + 8'h01) :
                                    psc_q[t];

    // end of a gated accumulation window
    assign gate_end[t] = run[t] & ~ctrl_i[t].clk_src
                       & ctrl_i[t].gate & gate_fall[t];

    // set wins over software clear
    assign flag_d[t] = flag_set[t] | (flag_q[t] & ~flag_clr_i[t]);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        psc_q[t] <= CTP_PSC_RST;
        cnt_q[t] <= CTP_CNT_RST;
      end else if (ce_i) begin
        psc_q[t] <= psc_d[t];
        cnt_q[t] <= cnt_d[t];
      end
    end

    assign count_o[t] = cnt_q[t];

  end : g_tmr

  // ---------------------------------------------------------------
  // pair logic: split or cascaded
  // ---------------------------------------------------------------
  for (genvar p = 0; p < CTP_NUM_PAIRS; p++) begin : g_pair

    localparam int LO = 2 * p;
    localparam int HI = 2 * p + 1;

    logic cas;
    logic lo_eq;
    logic hi_eq;
    logic lo_carry;
    logic m32;
    logic m16_lo;
    logic m16_hi;
    logic lo_wrap;
    logic hi_wrap;
    logic hi_inc;

    // only the lower control word selects cascade
    assign cas = ctrl_i[LO].cascade;

    assign lo_eq    = cnt_q[LO] == period_i[LO];
    assign hi_eq    = cnt_q[HI] == period_i[HI];
    assign lo_carry = cnt_q[LO] == CTP_CNT_MAX;

    // 32-bit compare of {upper, lower} on the lower timer's tick
    assign m32    = cas & psc_hit[LO] & lo_eq & hi_eq;
    assign m16_lo = ~cas & psc_hit[LO] & lo_eq;
    assign m16_hi = ~cas & psc_hit[HI] & hi_eq;

    assign lo_wrap = cas ? m32 : m16_lo;
    assign hi_wrap = cas ? m32 : m16_hi;

    // upper advances on lower carry when cascaded
    assign hi_inc = cas ? (psc_hit[LO] & lo_carry)
                        : psc_hit[HI];

    assign cnt_d[LO] = ~psc_hit[LO] ? cnt_q[LO] :
                       lo_wrap      ? CTP_CNT_RST :
                                      CTP_CNT_W'(cnt_q[LO] + CTP_CNT_ONE);

    assign cnt_d[HI] = hi_wrap ? CTP_CNT_RST :
                       hi_inc  ? CTP_CNT_W'(cnt_q[HI] + CTP_CNT_ONE) :
                                 cnt_q[HI];

    // cascaded match reports through the upper flag only
    assign match[LO] = m16_lo;
    assign match[HI] = hi_wrap;

    assign flag_set[LO] = m16_lo | (~cas & gate_end[LO]);
    assign flag_set[HI] = hi_wrap
                        | (cas ? gate_end[LO] : gate_end[HI]);

  end : g_pair

  // ---------------------------------------------------------------
  // flags and event pulses
  // ---------------------------------------------------------------
  assign evt_d.dma_req    = match;
  assign evt_d.adc_trig   = match[1] | match[3];
  assign evt_d.tbase_tick = match[1:0];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= 4'h0;
      evt_q  <= CTP_EVT_RST;
    end else if (ce_i) begin
      flag_q <= flag_d;
      evt_q  <= evt_d;
    end
  end

  assign irq_flag_o = flag_q;
  assign evt_o      = evt_q;

endmodule : ctp_timer_pairs

/* File: testbench/ctp_pin_model.sv */
// external clock pin model: one rise every four core cycles
// pin rests low outside bursts
`timescale 1ns/10ps

module ctp_pin_model (
  input  wire logic clk_i,  // core clock
  input  wire logic en_i,   // burst enable
  output logic      ext_o   // clock pin
);
  logic [1:0] ph_q = 2'h0;
  initial ext_o = 1'b0;
  always @(posedge clk_i) begin
    ph_q <= en_i ? ph_q + 2'h1 : 2'h0;
    ext_o <= en_i & ph_q[1];
  end
endmodule : ctp_pin_model

/* File: testbench/ctp_timer_pairs_properties.sv */
// assertion checker for the timer pairs, bound to the top module
// sees only top-level ports; one core clock domain
`timescale 1ns/10ps

module ctp_timer_pairs_properties
  import ctp_pkg::*;
(
  input wire logic                      core_clk_i,  // clock
  input wire logic                      rstn_i,      // reset, low
  input wire logic                      ce_i,        // enable
  input wire logic                      idle_i,      // idle
  input wire logic                      sleep_i,     // sleep
  input wire ctp_ctrl_t [3:0]           ctrl_i,      // controls
  input wire logic [3:0][CTP_CNT_W-1:0] period_i,    // periods
  input wire logic [3:0]                ext_clk_i,   // ext clocks
  input wire logic [3:0]                gate_i,      // gates
  input wire logic [3:0]                flag_clr_i,  // clears
  input wire logic [3:0]                irq_flag_o,  // flags
  input wire logic [3:0][CTP_CNT_W-1:0] count_o,     // counts
  input wire ctp_evt_t                  evt_o        // events
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_low_wrap;
    ctrl_i[0].cascade && count_o[0] == CTP_CNT_MAX ##1 count_o[0] == CTP_CNT_RST;
  endsequence
  AST_ADC_SRC: assert property (evt_o.adc_trig == (evt_o.dma_req[1] | evt_o.dma_req[3]))
    else $error("adc trigger source");
  AST_TBASE: assert property (evt_o.tbase_tick == evt_o.dma_req[1:0])
    else $error("time base tick");
  AST_FLAG_SET: assert property ((evt_o.dma_req & ~irq_flag_o) == 4'h0)
    else $error("event without flag");
  AST_MATCH_ZERO: assert property (evt_o.dma_req[2] |-> count_o[2] == CTP_CNT_RST)
    else $error("count not zero after match");
  AST_FLAG_CLR: assert property ($fell(irq_flag_o[2]) |-> $past(flag_clr_i[2]))
    else $error("flag fell without clear");
  AST_LO_QUIET: assert property ($past(ctrl_i[0].cascade) |-> !evt_o.dma_req[0])
    else $error("lower timer event in cascade");
  AST_IDLE_STOP: assert property (idle_i && ctrl_i[0].stop_in_idle |=> $stable(count_o[0]))
    else $error("count moved in idle");
  AST_IDLE_RUN: assert property (idle_i && !sleep_i && ce_i && ctrl_i[0].on
    && {ctrl_i[0].stop_in_idle, ctrl_i[0].gate, ctrl_i[0].prescale, ctrl_i[0].clk_src} == 5'h00
    && period_i[0] != 16'h0000 |=> count_o[0] != $past(count_o[0]))
    else $error("count stuck in idle");
  AST_HI_CARRY: assert property (s_low_wrap |-> count_o[1] == CTP_CNT_RST
    || count_o[1] == $past(count_o[1]) + CTP_CNT_ONE)
    else $error("no carry into upper word");
  AST_HI_OFF: assert property (ctrl_i[0].cascade && !ctrl_i[0].on |=> $stable(count_o[1]))
    else $error("upper moved while pair off");
  AST_EXT_HOLD: assert property (ctrl_i[2].clk_src && !ext_clk_i[2] |=> $stable(count_o[2]))
    else $error("count without pin edge");
endmodule : ctp_timer_pairs_properties

bind ctp_timer_pairs ctp_timer_pairs_properties ctp_timer_pairs_properties_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .idle_i(idle_i),
  .sleep_i(sleep_i), .ctrl_i(ctrl_i), .period_i(period_i), .ext_clk_i(ext_clk_i),
  .gate_i(gate_i), .flag_clr_i(flag_clr_i), .irq_flag_o(irq_flag_o),
  .count_o(count_o), .evt_o(evt_o));

/* File: testbench/tb_top.sv */
// self-checking bench for the timer pairs
// inputs change on the falling edge; pin model feeds timer 2
`timescale 1ns/10ps

module tb_top
  import ctp_pkg::*;
;
  logic                      clk = 1'b0;
  logic                      rstn, ce, idle, slp, pin_en, pin;
  ctp_ctrl_t [3:0]           ctrl;
  logic [3:0][CTP_CNT_W-1:0] per, cnt;
  logic [3:0]                gate, clr, flag;
  ctp_evt_t                  evt;
  int                        err_count = 0;
  int                        checks = 0;
  int                        cyc = 0;
  always #2 clk = ~clk;
  ctp_pin_model ctp_pin_model_inst (.clk_i(clk), .en_i(pin_en), .ext_o(pin));
  ctp_timer_pairs ctp_timer_pairs_inst (
    .core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .idle_i(idle), .sleep_i(slp),
    .ctrl_i(ctrl), .period_i(per), .ext_clk_i({1'b0, pin, 2'b00}), .gate_i(gate),
    .flag_clr_i(clr), .irq_flag_o(flag), .count_o(cnt), .evt_o(evt));
  task automatic end_sim();
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic t_split();
    idle = 1'b1;
    for (int t = 0; t < 4; t++) begin
      per[t] = 16'h0002;
      ctrl[t] = '{on: 1'b1, default: '0};
      tick(3);
      cmp(7'(evt), {4'h1 << t, t[0], t < 2 ? 2'h1 << t : 2'h0});
      cmp(cnt[t], 0);
      cmp(flag, 4'h1 << t);
      ctrl[t] = '0;
      clr[t] = 1'b1;
      tick(1);
      clr = '0;
      cmp(flag, 0);
    end
    idle = 1'b0;
  endtask : t_split
  task automatic t_cascade();
    int i;
    per[1:0] = {16'h0001, 16'h0001};
    ctrl[1] = '{on: 1'b1, gate: 1'b1, prescale: 2'h3, default: '0};
    ctrl[0] = '{cascade: 1'b1, default: '0};
    tick(2);
    ctrl[0].on = 1'b1;
    for (i = 0; i < 70000 && evt.dma_req[1] !== 1'b1; i++) tick(1);
    cmp(i, 32'h0001_0002);
    cmp(7'(evt), {4'h2, 1'b1, 2'h2});
    cmp(flag, 4'h2);
    cmp({cnt[1], cnt[0]}, 0);
    ctrl[1:0] = '0;
    clr = 4'h2;
    tick(1);
    clr = '0;
  endtask : t_cascade
  task automatic t_misc();
    {slp, per[2]} = {1'b1, 16'hffff};
    ctrl[2] = '{on: 1'b1, clk_src: 1'b1, default: '0};
    pin_en = 1'b1;
    tick(20);
    pin_en = 1'b0;
    tick(4);
    cmp(cnt[2], 5);
    {slp, ctrl[2], idle, per[0]} = {1'b0, 7'h00, 1'b1, 16'hffff};
    ctrl[0] = '{on: 1'b1, stop_in_idle: 1'b1, default: '0};
    tick(10);
    cmp(cnt[0], 0);
    idle = 1'b0;
    tick(5);
    cmp(cnt[0], 5);
    ce = 1'b0;
    tick(3);
    cmp(cnt[0], 5);
    ce = 1'b1;
    {ctrl[0], per[1], gate[1]} = {7'h00, 16'hffff, 1'b1};
    ctrl[1] = '{on: 1'b1, gate: 1'b1, default: '0};
    tick(4);
    gate[1] = 1'b0;
    tick(2);
    cmp({flag, cnt[1]}, {4'h2, 16'h0004});
    {ctrl[1], per[3]} = {7'h00, 16'hffff};
    ctrl[3] = '{on: 1'b1, prescale: 2'h1, default: '0};
    tick(16);
    cmp(cnt[3], 2);
  endtask : t_misc
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count = err_count + 1;
      end_sim();
    end
  end
  initial begin
    {rstn, idle, slp, pin_en, ctrl, per, gate, clr} = '0;
    ce = 1'b1;
    tick(16);
    rstn = 1'b1;
    tick(1);
    t_split();
    t_cascade();
    t_misc();
    end_sim();
  end
endmodule : tb_top
